// file: hdl/rstxf_pkg.sv
// rstxf_pkg: constants and carrier types of the raw serial transmit framer.
// assumes a 200 MHz system clock and a 32-bit Avalon-MM register slave.
package rstxf_pkg;

	////////////////////////////////////////////////////////////////////////////
	// clock and line timing
	localparam int unsigned CLK_HZ           = 200_000_000;       // system clock rate
	localparam int unsigned LINE_BAUD        = 38_400;            // default line rate in bit/s
	localparam int unsigned BIT_CYCLES_RESET = CLK_HZ / LINE_BAUD; // clocks per bit, rounded down

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [11:0] OFF_COMMAND  = 12'h000; // write bit 0 to request a send
	localparam logic [11:0] OFF_CONTROL  = 12'h004; // control word
	localparam logic [11:0] OFF_COUNT    = 12'h008; // data byte count
	localparam logic [11:0] OFF_PORT0    = 12'h00C; // frame setup, built-in port
	localparam logic [11:0] OFF_PORT1    = 12'h010; // frame setup, option-board port
	localparam logic [11:0] OFF_GAP      = 12'h014; // idle clocks after each frame
	localparam logic [11:0] OFF_STATUS   = 12'h018; // live status
	localparam logic [11:0] OFF_IRQ_STAT = 12'h01C; // sticky events, cleared by read
	localparam logic [11:0] OFF_IRQ_MASK = 12'h020; // event enables
	localparam logic [11:0] OFF_BITTIME  = 12'h024; // clocks per line bit
	localparam logic [11:0] OFF_BUF_BASE = 12'h400; // source words, one per 32-bit slot

	////////////////////////////////////////////////////////////////////////////
	// field positions and limits
	localparam int unsigned STAT_ERROR  = 0;  // error flag
	localparam int unsigned STAT_BUSY   = 1;  // frame in progress
	localparam int unsigned STAT_RDY0   = 2;  // send ready, built-in port
	localparam int unsigned STAT_RDY1   = 3;  // send ready, option-board port
	localparam int unsigned IRQ_DONE    = 0;  // frame finished
	localparam int unsigned IRQ_ERROR   = 1;  // request refused
	localparam int unsigned BUF_WORDS   = 128; // source words held
	localparam logic [15:0] COUNT_MAX   = 16'h0100; // largest data byte count
	localparam logic [3:0]  PORT_BUILTIN = 4'h0;   // port select codes
	localparam logic [3:0]  PORT_OPTION  = 4'h1;
	localparam logic [3:0]  ORDER_HI_LO  = 4'h0;   // upper byte of each word first
	localparam logic [3:0]  ORDER_LO_HI  = 4'h1;   // lower byte of each word first
	localparam logic [3:0]  MODEM_NONE   = 4'h0;
	localparam logic [3:0]  MODEM_RTS    = 4'h1;
	localparam logic [3:0]  MODEM_DTR    = 4'h2;
	localparam logic [3:0]  MODEM_BOTH   = 4'h3;
	localparam logic [1:0]  END_NONE     = 2'h0;   // end code choices
	localparam logic [1:0]  END_CRLF     = 2'h1;
	localparam logic [1:0]  END_BYTE     = 2'h2;
	localparam logic [7:0]  CHAR_CR      = 8'h0D;
	localparam logic [7:0]  CHAR_LF      = 8'h0A;
	localparam logic [15:0] GAP_RESET    = 16'h0000;
	localparam logic [31:0] PORT_RESET   = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [3:0] reserved; // must be zero
		logic [3:0] port;     // 11:8 port select
		logic [3:0] modem;    // 7:4 modem-line control
		logic [3:0] order;    // 3:0 byte order
	} rstxf_ctrl_t;

	typedef struct packed {
		logic [11:0] unused;     // 31:20 read as zero
		logic        no_proto;   // 19 port set to no-protocol mode
		logic [1:0]  end_mode;   // 18:17 end code choice
		logic        start_en;   // 16 start code enabled
		logic [7:0]  end_code;   // 15:8
		logic [7:0]  start_code; // 7:0
	} rstxf_port_t;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b00_0001,
		ST_SCODE = 6'b00_0010,
		ST_DATA  = 6'b00_0100,
		ST_END1  = 6'b00_1000,
		ST_END2  = 6'b01_0000,
		ST_GAP   = 6'b10_0000
	} rstxf_state_t;

endpackage : rstxf_pkg

// file: hdl/rstxf_top.sv
// rstxf_top: raw serial transmit framer with two serial ports and an Avalon-MM slave.
// assumes one 200 MHz clock, a synchronous active-low reset and a well-behaved bus master.
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps

// Contract
// - send count bytes from words unaltered
// - control bits 11:8 pick the port
// - optional start byte sent before data
// - optional end code: CR+LF or byte
// - count covers data only, not codes
// - at most 256 data bytes, 259 total
// - control bits 3:0 give byte order
// - modem field drives RTS/DTR from word bits
// - modem request ignores send-ready flag
// - otherwise send only while send-ready
// - zero count sends nothing
// - error unless port in no-protocol mode
// - error when count above 0100 hex
// - error on bad control, else cleared
// - configurable gap between frames
// - send-ready only when port can accept
// - error when sending without send-ready
module rstxf_top import rstxf_pkg::*; #(
	parameter logic [15:0] BIT_CYCLES_DEFAULT = 16'(BIT_CYCLES_RESET) // reset value of bit time
) (
	input  wire logic        CLOCK_I,                 // system clock
	input  wire logic        RST_N_I,                 // synchronous reset, active low
	input  wire logic [11:0] AVS_ADDRESS_I,           // byte address
	input  wire logic        AVS_READ_I,              // read request
	input  wire logic        AVS_WRITE_I,             // write request
	input  wire logic [31:0] AVS_WRITEDATA_I,         // write data
	input  wire logic [3:0]  AVS_BYTEENABLE_I,        // write lanes
	output logic      [31:0] AVS_READDATA_O,          // read data
	output logic             AVS_WAITREQUEST_O,       // stall
	output logic             TXD0_O,                  // serial out, built-in port
	output logic             TXD1_O,                  // serial out, option-board port
	output logic      [1:0]  REQUEST_TO_SEND_LINE_O,  // per port
	output logic      [1:0]  TERMINAL_READY_LINE_O,   // per port
	output logic             ERROR_FLAG_O,            // level
	output logic             IRQ_O                    // level interrupt
);

	////////////////////////////////////////////////////////////////////////////
	// functions

	// merge enabled byte lanes of new data over old
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
	                                           input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	// check the control word against the codes this block knows
	function automatic logic ctrl_ok(input rstxf_ctrl_t c);
		return (c.reserved == 4'h0) &&
		       (c.port == PORT_BUILTIN || c.port == PORT_OPTION) &&
		       (c.order == ORDER_HI_LO || c.order == ORDER_LO_HI) &&
		       (c.modem <= MODEM_BOTH);
	endfunction : ctrl_ok

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [15:0]  src_mem [BUF_WORDS];  // source words
	rstxf_ctrl_t  ctrl;                 // control word as written
	logic [15:0]  count;                // requested data bytes
	rstxf_port_t  port_cfg [2];         // per-port frame setup
	logic [15:0]  gap;                  // idle clocks after a frame
	logic [15:0]  bit_time;             // clocks per line bit
	logic [1:0]   irq_stat;             // sticky events
	logic [1:0]   irq_mask;             // event enables
	logic         bus_ack;              // second cycle of an access
	logic         bus_wr;               // write takes effect this cycle
	logic         bus_rd;               // read completes this cycle
	logic         go;                   // send request written
	logic         p_sel;                // port picked by the request
	logic         req_err;              // request refused
	logic         req_modem;            // modem option requested
	logic         req_start;            // frame accepted
	logic         ev_done;              // frame finished
	logic [1:0]   ready;                // send-ready per port
	rstxf_state_t state;                // byte sequencer
	logic         f_port;               // latched port
	logic         f_lohi;               // latched byte order
	logic [8:0]   f_left;               // data bytes still to send
	logic [7:0]   f_idx;                // next source word
	logic         f_half;               // second byte of the word next
	rstxf_port_t  f_cfg;                // latched frame setup
	logic [15:0]  gap_cnt;              // gap countdown
	logic         sh_busy;              // shifter running
	logic [9:0]   sh_reg;               // stop, data, start
	logic [3:0]   sh_bits;              // bits left
	logic [15:0]  sh_cnt;               // clocks left in this bit
	logic         load;                 // hand a byte to the shifter
	logic [7:0]   load_byte;            // byte handed over
	logic [15:0]  cur_word;             // word under the data pointer
	logic [31:0]  next_readdata;        // read mux

	////////////////////////////////////////////////////////////////////////////
	// bus handshake: every access takes one wait cycle, so readdata is a flop
	assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !bus_ack;
	assign bus_wr            = AVS_WRITE_I && bus_ack;
	assign bus_rd            = AVS_READ_I && bus_ack;

	// ack toggles on for exactly one cycle per access
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= (AVS_READ_I || AVS_WRITE_I) && !bus_ack;
		end
	end

	// read mux; unmapped addresses below OFF_BUF_BASE read zero, those above the buffer alias it
	always_comb begin
		next_readdata = 32'h0000_0000;
		if (AVS_ADDRESS_I >= OFF_BUF_BASE) begin
			next_readdata = {16'h0000, src_mem[AVS_ADDRESS_I[8:2]]};
		end else begin
			case (AVS_ADDRESS_I)
				OFF_CONTROL:  next_readdata = {16'h0000, ctrl};
				OFF_COUNT:    next_readdata = {16'h0000, count};
				OFF_PORT0:    next_readdata = port_cfg[0];
				OFF_PORT1:    next_readdata = port_cfg[1];
				OFF_GAP:      next_readdata = {16'h0000, gap};
				OFF_STATUS:   next_readdata = {28'h000_0000, ready, (state != ST_IDLE), ERROR_FLAG_O};
				OFF_IRQ_STAT: next_readdata = {30'h0000_0000, irq_stat};
				OFF_IRQ_MASK: next_readdata = {30'h0000_0000, irq_mask};
				OFF_BITTIME:  next_readdata = {16'h0000, bit_time};
				default:      next_readdata = 32'h0000_0000;
			endcase
		end
	end

	// capture read data at the first cycle so it stands when waitrequest falls
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			AVS_READDATA_O <= 32'h0000_0000;
		end else if (AVS_READ_I && !bus_ack) begin
			AVS_READDATA_O <= next_readdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software-written registers
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			ctrl        <= '0;
			count       <= 16'h0000;
			port_cfg[0] <= PORT_RESET;
			port_cfg[1] <= PORT_RESET;
			gap         <= GAP_RESET;
			bit_time    <= BIT_CYCLES_DEFAULT;
			irq_mask    <= 2'b00;
		end else if (bus_wr) begin
			case (AVS_ADDRESS_I)
				OFF_CONTROL:  ctrl        <= rstxf_ctrl_t'(16'(lane_merge({16'h0000, ctrl}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I)));
				OFF_COUNT:    count       <= 16'(lane_merge({16'h0000, count}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
				OFF_PORT0:    port_cfg[0] <= {12'h000, 20'(lane_merge(port_cfg[0], AVS_WRITEDATA_I, AVS_BYTEENABLE_I))};
				OFF_PORT1:    port_cfg[1] <= {12'h000, 20'(lane_merge(port_cfg[1], AVS_WRITEDATA_I, AVS_BYTEENABLE_I))};
				OFF_GAP:      gap         <= 16'(lane_merge({16'h0000, gap}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
				OFF_IRQ_MASK: irq_mask    <= 2'(lane_merge({30'h0000_0000, irq_mask}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
				OFF_BITTIME:  bit_time    <= 16'(lane_merge({16'h0000, bit_time}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
				default:      ;
			endcase
		end
	end

	// source word memory, low two lanes only
	always_ff @(posedge CLOCK_I) begin
		if (bus_wr && AVS_ADDRESS_I >= OFF_BUF_BASE) begin
			src_mem[AVS_ADDRESS_I[8:2]] <= 16'(lane_merge({16'h0000, src_mem[AVS_ADDRESS_I[8:2]]},
			                                              AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// request check
	assign go        = bus_wr && (AVS_ADDRESS_I == OFF_COMMAND) && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[0];
	assign p_sel     = (ctrl.port == PORT_OPTION);
	assign req_modem = (ctrl.modem != MODEM_NONE);
	assign ready[0]  = port_cfg[0].no_proto && (state == ST_IDLE);
	assign ready[1]  = port_cfg[1].no_proto && (state == ST_IDLE);
	// modem requests skip the ready check; a busy engine still cannot take a frame
	assign req_err   = !ctrl_ok(ctrl) ||
	                   (count > COUNT_MAX) ||
	                   !port_cfg[p_sel].no_proto ||
	                   (!req_modem && !ready[p_sel]);
	assign req_start = go && !req_err && (count != 16'h0000) && (state == ST_IDLE);

	// error flag follows each request: set on a refused one, cleared on a good one
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			ERROR_FLAG_O <= 1'b0;
		end else if (go) begin
			ERROR_FLAG_O <= req_err;
		end
	end

	// modem lines take bit 15 of the first source word; with both lines driven, DTR takes bit 14
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			REQUEST_TO_SEND_LINE_O <= 2'b00;
			TERMINAL_READY_LINE_O  <= 2'b00;
		end else if (go && !req_err) begin
			case (ctrl.modem)
				MODEM_RTS: REQUEST_TO_SEND_LINE_O[p_sel] <= src_mem[0][15];
				MODEM_DTR: TERMINAL_READY_LINE_O[p_sel]  <= src_mem[0][15];
				MODEM_BOTH: begin
					REQUEST_TO_SEND_LINE_O[p_sel] <= src_mem[0][15];
					TERMINAL_READY_LINE_O[p_sel]  <= src_mem[0][14];
				end
				default: ; // no modem option: lines keep their level
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// byte sequencer: start code, data, end code, then the gap
	assign cur_word  = src_mem[f_idx[6:0]];
	assign load      = !sh_busy && (state == ST_SCODE || state == ST_DATA || state == ST_END1 || state == ST_END2);

	// pick the byte for the shifter
	always_comb begin
		load_byte = 8'h00;
		case (state)
			ST_SCODE: load_byte = f_cfg.start_code;
			ST_DATA:  load_byte = (f_half ^ f_lohi) ? cur_word[7:0] : cur_word[15:8];
			ST_END1:  load_byte = (f_cfg.end_mode == END_CRLF) ? CHAR_CR : f_cfg.end_code;
			ST_END2:  load_byte = CHAR_LF;
			default:  load_byte = 8'h00;
		endcase
	end

	// state advance; the frame holds at most 1 + 256 + 2 bytes
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			state   <= ST_IDLE;
			f_port  <= 1'b0;
			f_lohi  <= 1'b0;
			f_left  <= 9'h000;
			f_idx   <= 8'h00;
			f_half  <= 1'b0;
			f_cfg   <= PORT_RESET;
			gap_cnt <= 16'h0000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (req_start) begin
						f_port <= p_sel;
						f_lohi <= (ctrl.order == ORDER_LO_HI);
						f_left <= count[8:0];
						f_idx  <= 8'h00;
						f_half <= 1'b0;
						f_cfg  <= port_cfg[p_sel];
						state  <= port_cfg[p_sel].start_en ? ST_SCODE : ST_DATA;
					end
				end
				ST_SCODE: begin
					if (load) begin
						state <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (load) begin
						f_left <= f_left - 9'h001;
						f_half <= !f_half;
						if (f_half) begin
							f_idx <= f_idx + 8'h01;
						end
						if (f_left == 9'h001) begin
							state <= (f_cfg.end_mode == END_NONE) ? ST_GAP : ST_END1;
						end
					end
				end
				ST_END1: begin
					if (load) begin
						state <= (f_cfg.end_mode == END_CRLF) ? ST_END2 : ST_GAP;
					end
				end
				ST_END2: begin
					if (load) begin
						state <= ST_GAP;
					end
				end
				ST_GAP: begin
					// wait for the last stop bit, then hold off for the gap
					if (sh_busy || load) begin
						gap_cnt <= gap;
					end else if (gap_cnt != 16'h0000) begin
						gap_cnt <= gap_cnt - 16'h0001;
					end else begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// gap entry must see the shifter busy; the load in the same cycle covers it
	assign ev_done = (state == ST_GAP) && !sh_busy && (gap_cnt == 16'h0000);

	////////////////////////////////////////////////////////////////////////////
	// bit shifter: 8N1, lsb first, idle high
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			sh_busy <= 1'b0;
			sh_reg  <= 10'h3FF;
			sh_bits <= 4'h0;
			sh_cnt  <= 16'h0000;
		end else if (load) begin
			sh_busy <= 1'b1;
			sh_reg  <= {1'b1, load_byte, 1'b0};
			sh_bits <= 4'hA;
			sh_cnt  <= bit_time;
		end else if (sh_busy) begin
			if (sh_cnt > 16'h0001) begin
				sh_cnt <= sh_cnt - 16'h0001;
			end else begin
				sh_cnt  <= bit_time;
				sh_reg  <= {1'b1, sh_reg[9:1]};
				sh_bits <= sh_bits - 4'h1;
				sh_busy <= (sh_bits != 4'h1);
			end
		end
	end

	// only the latched port sees the frame; the other idles high
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			TXD0_O <= 1'b1;
			TXD1_O <= 1'b1;
		end else begin
			TXD0_O <= (sh_busy && !f_port) ? sh_reg[0] : 1'b1;
			TXD1_O <= (sh_busy &&  f_port) ? sh_reg[0] : 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts: set wins over the read that clears
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			irq_stat <= 2'b00;
		end else begin
			irq_stat <= ((bus_rd && AVS_ADDRESS_I == OFF_IRQ_STAT) ? 2'b00 : irq_stat) |
			            {go && req_err, ev_done};
		end
	end

	assign IRQ_O = |(irq_stat & irq_mask);

endmodule : rstxf_top

// file: testbench/rstxf_props.sv
// rstxf_props: port-level checks of the raw serial transmit framer.
// assumes binding to rstxf_top and the reset bit time.
`timescale 1ns/100ps
module rstxf_props import rstxf_pkg::*; #(
	parameter logic [15:0] BIT_CYCLES_DEFAULT = 16'h0004 // clocks per line bit
) (
	input wire logic        CLOCK_I,
	input wire logic        RST_N_I,
	input wire logic [11:0] AVS_ADDRESS_I,
	input wire logic        AVS_READ_I,
	input wire logic        AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0]  AVS_BYTEENABLE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic        AVS_WAITREQUEST_O,
	input wire logic        TXD0_O,
	input wire logic        TXD1_O,
	input wire logic [1:0]  REQUEST_TO_SEND_LINE_O,
	input wire logic [1:0]  TERMINAL_READY_LINE_O,
	input wire logic        ERROR_FLAG_O,
	input wire logic        IRQ_O
);
	logic [15:0] low_cnt; // clocks of the current low stretch on TXD0_O
	logic        req;     // any bus request
	logic        cmd;     // send command completing this cycle
	assign req = AVS_READ_I | AVS_WRITE_I;
	assign cmd = AVS_WRITE_I & ~AVS_WAITREQUEST_O & (AVS_ADDRESS_I == OFF_COMMAND) & AVS_WRITEDATA_I[0];
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	////////////////////////////////////////////////////////////////////////////
	// length of each low stretch on TXD0_O
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I || TXD0_O) low_cnt <= 16'h0000;
		else low_cnt <= low_cnt + 16'h0001;
	end
	////////////////////////////////////////////////////////////////////////////
	sequence s_req_start;
		req && !$past(req);
	endsequence
	sequence s_one_wait;
		AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
	endsequence
	property p_wait_one; s_req_start |-> s_one_wait; endproperty
	a_wait_one: assert property (p_wait_one) else $error("no answer after one wait");
	property p_idle_nowait; !req |-> !AVS_WAITREQUEST_O; endproperty
	a_idle_nowait: assert property (p_idle_nowait) else $error("stall with no access");
	property p_err_hold; !cmd |=> $stable(ERROR_FLAG_O); endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag moved alone");
	property p_modem_hold; !cmd |=> $stable(REQUEST_TO_SEND_LINE_O) && $stable(TERMINAL_READY_LINE_O); endproperty
	a_modem_hold: assert property (p_modem_hold) else $error("modem line moved alone");
	property p_one_port; !(!TXD0_O && !TXD1_O); endproperty
	a_one_port: assert property (p_one_port) else $error("both ports sending at once");
	// limitation: software must keep the reset bit time
	property p_whole_bits; $rose(TXD0_O) |-> low_cnt != 16'h0000 && low_cnt % BIT_CYCLES_DEFAULT == 16'h0000; endproperty
	a_whole_bits: assert property (p_whole_bits) else $error("low not whole bits");
	property p_irq_clear;
		$fell(IRQ_O) |-> $past(AVS_READ_I && AVS_ADDRESS_I == OFF_IRQ_STAT || AVS_WRITE_I && AVS_ADDRESS_I == OFF_IRQ_MASK);
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq fell alone");
	property p_rd_hold; !AVS_READ_I |=> $stable(AVS_READDATA_O); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved alone");
endmodule : rstxf_props

bind rstxf_top rstxf_props #(.BIT_CYCLES_DEFAULT(BIT_CYCLES_DEFAULT)) i_props (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
	.AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
	.AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .TXD0_O(TXD0_O), .TXD1_O(TXD1_O),
	.REQUEST_TO_SEND_LINE_O(REQUEST_TO_SEND_LINE_O), .TERMINAL_READY_LINE_O(TERMINAL_READY_LINE_O),
	.ERROR_FLAG_O(ERROR_FLAG_O), .IRQ_O(IRQ_O));

// file: testbench/rstxf_line_rx.sv
// rstxf_line_rx: receiving serial device, 8 data bits, no parity, one stop bit.
// assumes the line idles high and the bit time is fixed at BIT clocks.
`timescale 1ns/100ps
module rstxf_line_rx #(
	parameter int BIT = 4 // clocks per bit
) (
	input wire logic clk_i, // system clock, used as bit timer
	input wire logic line_i // serial line from the framer
);
	logic [7:0] q[$]; // bytes received, oldest first
	logic [7:0] b;    // byte being shifted in
	int         bad;  // stop bits seen low
	////////////////////////////////////////////////////////////////////////////
	// sample mid-bit so a one-clock skew of the edges does no harm
	initial begin
		bad = 0;
		forever begin
			@(negedge line_i);
			repeat (BIT / 2) @(posedge clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clk_i);
				b[i] = line_i; // lsb first
			end
			repeat (BIT) @(posedge clk_i);
			if (!line_i) bad++; // framing fault
			q.push_back(b);
		end
	end
endmodule : rstxf_line_rx

// file: testbench/rstxf_tb_top.sv
// rstxf_tb_top: self-checking bench of the raw serial transmit framer.
// assumes rstxf_top with its bound checker and two line receiver models.
`timescale 1ns/100ps
module rstxf_tb_top import rstxf_pkg::*;;
	localparam logic [15:0] BIT = 16'h0004; // short bit keeps frames brief
	logic        clk   = 1'b0;          // system clock
	logic        rst_n = 1'b0;          // reset, active low
	logic [11:0] adr   = 12'h000;       // bus address
	logic        rd    = 1'b0;          // bus read
	logic        wr    = 1'b0;          // bus write
	logic [31:0] wd    = 32'h0000_0000; // bus write data
	logic [31:0] rdata, r;              // read data, value taken
	logic        stall, txd0, txd1, err, irq;
	logic [1:0]  rts, dtr;              // modem lines per port
	logic [7:0]  exp_q[$];              // bytes expected on the line
	int          fail_count = 0;
	int          cmp_count = 0;
	always #2.5 clk = ~clk;
	rstxf_top #(.BIT_CYCLES_DEFAULT(BIT)) i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(stall), .TXD0_O(txd0), .TXD1_O(txd1),
		.REQUEST_TO_SEND_LINE_O(rts), .TERMINAL_READY_LINE_O(dtr), .ERROR_FLAG_O(err), .IRQ_O(irq));
	rstxf_line_rx #(.BIT(4)) i_rx0 (.clk_i(clk), .line_i(txd0));
	rstxf_line_rx #(.BIT(4)) i_rx1 (.clk_i(clk), .line_i(txd1));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one access; request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (stall !== 1'b0);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(r, e);
	endtask : rd_chk
	// send request; one edge more lets the error flag land
	task automatic go(input logic [31:0] ctrl, input logic [15:0] n);
		bus(1'b1, OFF_CONTROL, ctrl);
		bus(1'b1, OFF_COUNT, {16'h0000, n});
		bus(1'b1, OFF_COMMAND, 32'h0000_0001);
		@(posedge clk);
	endtask : go
	// polls busy, then compares one port's line with exp_q
	task automatic frame_chk(input logic sel);
		logic [7:0] got[$];
		int n;
		n = 0;
		do begin
			bus(1'b0, OFF_STATUS, 32'h0000_0000);
			n++;
		end while (r[STAT_BUSY] !== 1'b0 && n < 5000);
		if (sel) got = i_rx1.q;
		else got = i_rx0.q;
		chk(got.size(), exp_q.size());
		foreach (exp_q[k]) if (k < got.size()) chk(got[k], exp_q[k]);
		i_rx0.q.delete();
		i_rx1.q.delete();
		exp_q.delete();
	endtask : frame_chk
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_chk(OFF_STATUS, 32'h0000_0000);
		rd_chk(OFF_BITTIME, {16'h0000, BIT});
		bus(1'b1, 12'h0FC, 32'h0000_FFFF);
		rd_chk(12'h0FC, 32'h0000_0000);
	endtask : t_reset
	// 256 data bytes, start code, CR+LF: 259 on the line
	task automatic t_max();
		logic [7:0] v;
		bus(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
		bus(1'b1, OFF_PORT0, 32'h000B_0002);
		for (int i = 0; i < 128; i++) bus(1'b1, OFF_BUF_BASE + 12'(4 * i), {16'h0000, 8'(i), ~8'(i)});
		go(32'h0000_0000, 16'h0100);
		chk(err, 1'b0);
		exp_q = '{8'h02};
		for (int k = 0; k < 256; k++) begin
			v = 8'(k / 2);
			exp_q.push_back(k % 2 ? ~v : v);
		end
		exp_q.push_back(CHAR_CR);
		exp_q.push_back(CHAR_LF);
		frame_chk(1'b0);
		chk(irq, 1'b1);
		rd_chk(OFF_IRQ_STAT, 32'h0000_0001);
		@(posedge clk);
		chk(irq, 1'b0);
	endtask : t_max
	// both byte orders, both ports, both end code kinds
	task automatic t_frames();
		bus(1'b1, OFF_BUF_BASE, 32'h0000_4047);
		bus(1'b1, OFF_BUF_BASE + 12'h004, 32'h0000_4F00);
		bus(1'b1, OFF_PORT1, 32'h000C_5A00);
		go(32'h0000_0000, 16'h0003);
		exp_q = '{8'h02, 8'h40, 8'h47, 8'h4F, 8'h0D, 8'h0A};
		frame_chk(1'b0);
		go(32'h0000_0101, 16'h0003);
		exp_q = '{8'h47, 8'h40, 8'h00, 8'h5A};
		frame_chk(1'b1);
		rd_chk(OFF_STATUS, 32'h0000_000C);
		rd_chk(OFF_IRQ_STAT, 32'h0000_0001);
	endtask : t_frames
	// modem codes, count zero: lines follow word 0, nothing sent
	task automatic t_modem();
		logic [15:0] mw[4] = '{16'h8000, 16'h8000, 16'h4000, 16'h0000};
		logic [1:0]  me[4] = '{2'b01, 2'b11, 2'b10, 2'b00};
		logic [3:0]  mc[4] = '{MODEM_RTS, MODEM_DTR, MODEM_BOTH, MODEM_BOTH};
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, OFF_BUF_BASE, {16'h0000, mw[k]});
			go({24'h0000_00, mc[k], 4'h0}, 16'h0000);
			chk({dtr, rts}, {1'b0, me[k][1], 1'b0, me[k][0]});
			chk({err, 8'(i_rx0.q.size())}, 9'h000);
		end
	endtask : t_modem
	// refused: count, reserved, order, port, mode
	task automatic t_errors();
		logic [15:0] ec[5] = '{16'h0000, 16'h1000, 16'h0002, 16'h0200, 16'h0100};
		logic [15:0] en[5] = '{16'h0101, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
		bus(1'b1, OFF_PORT1, 32'h0000_0000);
		for (int k = 0; k < 5; k++) begin
			go({16'h0000, ec[k]}, en[k]);
			chk(err, 1'b1);
		end
		chk(irq, 1'b0);
		rd_chk(OFF_IRQ_STAT, 32'h0000_0002);
		go(32'h0000_0000, 16'h0000);
		chk({err, 8'(i_rx0.q.size() + i_rx1.q.size())}, 9'h000);
	endtask : t_errors
	// busy: plain request refused, modem one taken, no frame
	task automatic t_busy();
		bus(1'b1, OFF_BUF_BASE, 32'h0000_8040);
		go(32'h0000_0000, 16'h0002);
		rd_chk(OFF_STATUS, 32'h0000_0002);
		go(32'h0000_0000, 16'h0002);
		chk(err, 1'b1);
		go(32'h0000_0010, 16'h0002);
		chk({err, rts[0]}, 2'b01);
		exp_q = '{8'h02, 8'h80, 8'h40, 8'h0D, 8'h0A};
		frame_chk(1'b0);
		rd_chk(OFF_STATUS, 32'h0000_0004);
	endtask : t_busy
	////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_max();
		t_frames();
		t_modem();
		t_errors();
		t_busy();
		report_and_stop();
	end
	// scenarios need under 20k clocks
	initial begin
		#400_000;
		fail_count++;
		$display("Error at %0t: watchdog expired", $time);
		report_and_stop();
	end
endmodule : rstxf_tb_top
